/* File: core/eofm_pkg.sv */
// Constants shared by the encoder option fault monitor.
// Assumes a single 125 MHz clock domain and an APB register port.
`default_nettype none

package eofm_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS  = 8;
    localparam int LOSS_FILT_NS   = 10000;
    // Least time, so round up
    localparam int LOSS_FILT_CYC  =
        (LOSS_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SPEED_WIN_NS   = 1000000;
    localparam int SPEED_WIN_CYC  = SPEED_WIN_NS / CLK_PERIOD_NS;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_MAXFREQ   = 8'h08;
    localparam logic [7:0] ADDR_OSLEVEL   = 8'h0C;
    localparam logic [7:0] ADDR_POSREF    = 8'h10;
    localparam logic [7:0] ADDR_FWDLIM    = 8'h14;
    localparam logic [7:0] ADDR_REVLIM    = 8'h18;
    localparam logic [7:0] ADDR_POSITION  = 8'h1C;
    localparam logic [7:0] ADDR_SPEED     = 8'h20;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h24;
    localparam logic [7:0] ADDR_IRQ_CLR   = 8'h28;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'h2C;

    // ==========================================================
    // Field positions
    localparam int CTRL_POS_EN    = 0;
    localparam int CTRL_ABS_EN    = 1;
    localparam int CTRL_TRIP_RST  = 2;
    localparam int STAT_TRIP      = 0;
    localparam int STAT_PORT      = 1;
    localparam int STAT_CODE_LSB  = 8;
    // Cause bits in the fault and interrupt vectors
    localparam int CAUSE_LOSS     = 0;
    localparam int CAUSE_OVSPD    = 1;
    localparam int CAUSE_POSERR   = 2;
    localparam int CAUSE_RANGE    = 3;
    localparam int CAUSE_CONN     = 4;
    localparam int NUM_CAUSE      = 5;

    // ==========================================================
    // Reset values
    localparam logic [1:0]  CTRL_RST      = 2'h0;
    localparam logic [15:0] MAXFREQ_RST   = 16'hFFFF;
    localparam logic [7:0]  OSLEVEL_RST   = 8'h6E;
    localparam logic [31:0] FWDLIM_RST    = 32'h7FFFFFFF;
    localparam logic [31:0] REVLIM_RST    = 32'h80000000;

    // ==========================================================
    // Trip codes, decimal 60s and 70s
    localparam logic [7:0] CODE_BASE_FIRST  = 8'h3C;
    localparam logic [7:0] CODE_BASE_SECOND = 8'h46;
    localparam logic [7:0] IDX_LOSS   = 8'h00;
    localparam logic [7:0] IDX_OVSPD  = 8'h01;
    localparam logic [7:0] IDX_POSERR = 8'h02;
    localparam logic [7:0] IDX_RANGE  = 8'h03;
    localparam logic [7:0] IDX_CONN   = 8'h09;

    // ==========================================================
    // Limits and scales
    localparam logic [31:0] DEV_LIMIT   = 32'h000F4240;
    localparam logic [7:0]  PCT_SCALE   = 8'h64;

    typedef enum logic [1:0] {
        ST_MON  = 2'b01,
        ST_TRIP = 2'b10
    } eofm_state_t;

endpackage

`default_nettype wire

/* File: core/eofm_quad.sv */
// Quadrature decoder and position counter for the A/B encoder phases.
// Assumes phase inputs already synchronous to mclk.
`default_nettype none

module eofm_quad (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // Encoder phases
    input  wire logic        enc_a,
    input  wire logic        enc_b,
    // Position and count strobe
    output logic [31:0]      pos_reg,
    output logic             step_reg
);
    import eofm_pkg::*;

    logic [1:0]  ab_reg;
    logic [1:0]  ab_next;
    logic [31:0] pos_next;
    logic        step_next;

    // ==========================================================
    // Decode
    always_comb begin
        ab_next   = {enc_a, enc_b};
        pos_next  = pos_reg;
        step_next = 1'b0;
        // Gray step forward: 00-10-11-01; a double jump is ignored
        unique case ({ab_reg, ab_next})
            4'h2, 4'hB, 4'hD, 4'h4: begin
                pos_next  = pos_reg + 32'h00000001;
                step_next = 1'b1;
            end
            4'h1, 4'h7, 4'hE, 4'h8: begin
                pos_next  = pos_reg - 32'h00000001;
                step_next = 1'b1;
            end
            default: begin
                pos_next  = pos_reg;
                step_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ab_reg   <= 2'h0;
            pos_reg  <= 32'h00000000;
            step_reg <= 1'b0;
        end else begin
            ab_reg   <= ab_next;
            pos_reg  <= pos_next;
            step_reg <= step_next;
        end
    end

endmodule

`default_nettype wire

/* File: core/eofm_top.sv */
// Encoder option board fault monitor with APB register port.
// Assumes encoder and board pins synchronous to mclk, one clock domain.
`default_nettype none

module eofm_top #(
    parameter int SPEED_WIN = eofm_pkg::SPEED_WIN_CYC
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Encoder line-driver pairs
    input  wire logic        enc_a,
    input  wire logic        enc_a_n,
    input  wire logic        enc_b,
    input  wire logic        enc_b_n,
    // Board mounting
    input  wire logic        board_seated,
    input  wire logic        option_port_second,
    // Control core
    input  wire logic        trip_reset_req,
    output logic             drive_off,
    output logic             trip_active,
    output logic [7:0]       trip_code,
    output logic             irq
);
    import eofm_pkg::*;

    // ==========================================================
    // Position counter
    logic [31:0] pos_w;
    logic        step_w;

    eofm_quad u_quad (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .enc_a    (enc_a),
        .enc_b    (enc_b),
        .pos_reg  (pos_w),
        .step_reg (step_w)
    );

    // ==========================================================
    // Register state
    logic [1:0]           ctrl_reg,    ctrl_next;
    logic [15:0]          max_output_frequency_reg, max_output_frequency_next;
    logic [7:0]           overspeed_detect_level_reg;
    logic [7:0]           overspeed_detect_level_next;
    logic [31:0]          posref_reg,  posref_next;
    logic [31:0]          forward_position_limit_reg;
    logic [31:0]          forward_position_limit_next;
    logic [31:0]          reverse_position_limit_reg;
    logic [31:0]          reverse_position_limit_next;
    logic [NUM_CAUSE-1:0] irq_stat_reg, irq_stat_next;
    logic [NUM_CAUSE-1:0] irq_en_reg,  irq_en_next;
    logic [31:0]          prdata_reg,  prdata_next;
    logic                 pready_reg,  pready_next;
    logic                 pslverr_reg, pslverr_next;
    logic                 irq_reg,     irq_next;
    logic                 sw_reset_reg, sw_reset_next;

    // Monitor state
    eofm_state_t          state_reg,   state_next;
    logic [7:0]           code_reg,    code_next;
    logic                 drive_off_reg, drive_off_next;
    logic                 port_reg,    port_next;
    logic [10:0]          loss_cnt_reg, loss_cnt_next;
    logic [23:0]          win_cnt_reg, win_cnt_next;
    logic [15:0]          edge_cnt_reg, edge_cnt_next;
    logic [15:0]          speed_reg,   speed_next;

    // Fault detection terms
    logic [NUM_CAUSE-1:0] fault;
    logic [32:0]          dev;
    logic [32:0]          dev_abs;
    logic [23:0]          speed_scaled;
    logic [23:0]          speed_limit;
    logic                 access;
    logic                 wr;
    logic                 mapped;

    // ==========================================================
    // Fault detection
    always_comb begin
        dev          = {pos_w[31], pos_w} - {posref_reg[31], posref_reg};
        dev_abs      = dev[32] ? (33'h000000000 - dev) : dev;
        speed_scaled = speed_reg * PCT_SCALE;
        speed_limit  = max_output_frequency_reg * overspeed_detect_level_reg;
        fault        = '0;
        // Complementary pair equal means an open wire or no line driver
        fault[CAUSE_LOSS]   = (loss_cnt_reg >= 11'(LOSS_FILT_CYC));
        fault[CAUSE_OVSPD]  = (speed_scaled > speed_limit);
        fault[CAUSE_POSERR] = ctrl_reg[CTRL_POS_EN]
                              && (dev_abs > {1'b0, DEV_LIMIT});
        fault[CAUSE_RANGE]  = ctrl_reg[CTRL_ABS_EN]
            && (($signed(pos_w) > $signed(forward_position_limit_reg))
             || ($signed(pos_w) < $signed(reverse_position_limit_reg)));
        fault[CAUSE_CONN]   = !board_seated;
    end

    // ==========================================================
    // Monitor and trip latch
    always_comb begin
        state_next     = state_reg;
        code_next      = code_reg;
        drive_off_next = drive_off_reg;
        port_next      = port_reg;
        loss_cnt_next  = loss_cnt_reg;
        win_cnt_next   = win_cnt_reg + 24'h000001;
        edge_cnt_next  = edge_cnt_reg;
        speed_next     = speed_reg;

        // Filter so a single glitch on a pair does not trip
        if ((enc_a == enc_a_n) || (enc_b == enc_b_n)) begin
            if (!fault[CAUSE_LOSS]) begin
                loss_cnt_next = loss_cnt_reg + 11'h001;
            end
        end else begin
            loss_cnt_next = 11'h000;
        end

        if (step_w && (edge_cnt_reg != 16'hFFFF)) begin
            edge_cnt_next = edge_cnt_reg + 16'h0001;
        end
        if (win_cnt_reg >= 24'(SPEED_WIN - 1)) begin
            win_cnt_next  = 24'h000000;
            speed_next    = edge_cnt_next;
            edge_cnt_next = 16'h0000;
        end

        unique case (state_reg)
            ST_MON: begin
                // Port is only tracked while idle so a code never shifts
                port_next      = option_port_second;
                drive_off_next = 1'b0;
                code_next      = 8'h00;
                if (|fault) begin
                    state_next     = ST_TRIP;
                    drive_off_next = 1'b1;
                    code_next      = option_port_second ? CODE_BASE_SECOND
                                                        : CODE_BASE_FIRST;
                    if (fault[CAUSE_CONN]) begin
                        code_next = code_next + IDX_CONN;
                    end else if (fault[CAUSE_LOSS]) begin
                        code_next = code_next + IDX_LOSS;
                    end else if (fault[CAUSE_OVSPD]) begin
                        code_next = code_next + IDX_OVSPD;
                    end else if (fault[CAUSE_POSERR]) begin
                        code_next = code_next + IDX_POSERR;
                    end else begin
                        code_next = code_next + IDX_RANGE;
                    end
                end
            end
            ST_TRIP: begin
                drive_off_next = 1'b1;
                // A fault still present trips again on the next cycle
                if (trip_reset_req || sw_reset_reg) begin
                    state_next     = ST_MON;
                    drive_off_next = 1'b0;
                    code_next      = 8'h00;
                end
            end
            default: begin
                state_next     = ST_TRIP;
                drive_off_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg     <= ST_MON;
            code_reg      <= 8'h00;
            drive_off_reg <= 1'b0;
            port_reg      <= 1'b0;
            loss_cnt_reg  <= 11'h000;
            win_cnt_reg   <= 24'h000000;
            edge_cnt_reg  <= 16'h0000;
            speed_reg     <= 16'h0000;
        end else begin
            state_reg     <= state_next;
            code_reg      <= code_next;
            drive_off_reg <= drive_off_next;
            port_reg      <= port_next;
            loss_cnt_reg  <= loss_cnt_next;
            win_cnt_reg   <= win_cnt_next;
            edge_cnt_reg  <= edge_cnt_next;
            speed_reg     <= speed_next;
        end
    end

    // ==========================================================
    // APB registers and interrupt
    always_comb begin
        access = psel && penable;
        // One wait state so read data can come from a flop
        pready_next = access && !pready_reg;
        wr          = access && pready_reg && pwrite;
        unique case (paddr)
            ADDR_CTRL, ADDR_STATUS, ADDR_MAXFREQ, ADDR_OSLEVEL,
            ADDR_POSREF, ADDR_FWDLIM, ADDR_REVLIM, ADDR_POSITION,
            ADDR_SPEED, ADDR_IRQ_STAT, ADDR_IRQ_CLR, ADDR_IRQ_EN:
                mapped = 1'b1;
            default:
                mapped = 1'b0;
        endcase
        pslverr_next = pready_next && !mapped;

        ctrl_next                   = ctrl_reg;
        max_output_frequency_next   = max_output_frequency_reg;
        overspeed_detect_level_next = overspeed_detect_level_reg;
        posref_next                 = posref_reg;
        forward_position_limit_next = forward_position_limit_reg;
        reverse_position_limit_next = reverse_position_limit_reg;
        irq_en_next                 = irq_en_reg;
        sw_reset_next               = 1'b0;
        irq_stat_next               = irq_stat_reg;

        if (wr) begin
            unique case (paddr)
                ADDR_CTRL: begin
                    ctrl_next     = pwdata[1:0];
                    sw_reset_next = pwdata[CTRL_TRIP_RST];
                end
                ADDR_MAXFREQ:  max_output_frequency_next   = pwdata[15:0];
                ADDR_OSLEVEL:  overspeed_detect_level_next = pwdata[7:0];
                ADDR_POSREF:   posref_next                 = pwdata;
                ADDR_FWDLIM:   forward_position_limit_next = pwdata;
                ADDR_REVLIM:   reverse_position_limit_next = pwdata;
                ADDR_IRQ_CLR:
                    irq_stat_next = irq_stat_reg & ~pwdata[NUM_CAUSE-1:0];
                ADDR_IRQ_EN:   irq_en_next = pwdata[NUM_CAUSE-1:0];
                default: begin
                end
            endcase
        end
        // Setting after the clear lets a same-cycle event win
        irq_stat_next = irq_stat_next | fault;
        irq_next      = |(irq_stat_next & irq_en_next);

        prdata_next = 32'h00000000;
        if (pready_next && !pwrite) begin
            unique case (paddr)
                ADDR_CTRL:     prdata_next = {30'h00000000, ctrl_reg};
                ADDR_STATUS: begin
                    prdata_next[STAT_TRIP] = (state_reg == ST_TRIP);
                    prdata_next[STAT_PORT] = port_reg;
                    prdata_next[STAT_CODE_LSB +: 8] = code_reg;
                end
                ADDR_MAXFREQ:  prdata_next = {16'h0000,
                                              max_output_frequency_reg};
                ADDR_OSLEVEL:  prdata_next = {24'h000000,
                                              overspeed_detect_level_reg};
                ADDR_POSREF:   prdata_next = posref_reg;
                ADDR_FWDLIM:   prdata_next = forward_position_limit_reg;
                ADDR_REVLIM:   prdata_next = reverse_position_limit_reg;
                ADDR_POSITION: prdata_next = pos_w;
                ADDR_SPEED:    prdata_next = {16'h0000, speed_reg};
                ADDR_IRQ_STAT: prdata_next = {27'h0000000, irq_stat_reg};
                ADDR_IRQ_EN:   prdata_next = {27'h0000000, irq_en_reg};
                default:       prdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_reg                   <= CTRL_RST;
            max_output_frequency_reg   <= MAXFREQ_RST;
            overspeed_detect_level_reg <= OSLEVEL_RST;
            posref_reg                 <= 32'h00000000;
            forward_position_limit_reg <= FWDLIM_RST;
            reverse_position_limit_reg <= REVLIM_RST;
            irq_stat_reg               <= '0;
            irq_en_reg                 <= '0;
            prdata_reg                 <= 32'h00000000;
            pready_reg                 <= 1'b0;
            pslverr_reg                <= 1'b0;
            irq_reg                    <= 1'b0;
            sw_reset_reg               <= 1'b0;
        end else begin
            ctrl_reg                   <= ctrl_next;
            max_output_frequency_reg   <= max_output_frequency_next;
            overspeed_detect_level_reg <= overspeed_detect_level_next;
            posref_reg                 <= posref_next;
            forward_position_limit_reg <= forward_position_limit_next;
            reverse_position_limit_reg <= reverse_position_limit_next;
            irq_stat_reg               <= irq_stat_next;
            irq_en_reg                 <= irq_en_next;
            prdata_reg                 <= prdata_next;
            pready_reg                 <= pready_next;
            pslverr_reg                <= pslverr_next;
            irq_reg                    <= irq_next;
            sw_reset_reg               <= sw_reset_next;
        end
    end

    assign prdata      = prdata_reg;
    assign pready      = pready_reg;
    assign pslverr     = pslverr_reg;
    assign drive_off   = drive_off_reg;
    assign trip_active = (state_reg == ST_TRIP);
    assign trip_code   = code_reg;
    assign irq         = irq_reg;

endmodule

`default_nettype wire

/* File: bench/eofm_monitor.sv */
// Checker of trip behaviour and APB answer timing of eofm_top.
// Assumes binding to eofm_top and sight of its ports only.
`default_nettype none

module eofm_monitor import eofm_pkg::*; (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       sys_rst,
    // APB
    input wire logic [7:0] paddr,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic       pready,
    // Board and trip
    input wire logic       board_seated,
    input wire logic       option_port_second,
    input wire logic       trip_reset_req,
    input wire logic       drive_off,
    input wire logic       trip_active,
    input wire logic [7:0] trip_code
);
    // ==========================================================
    // Properties
    logic ctrl_wr;
    assign ctrl_wr = psel && penable && pready && pwrite
                     && paddr == ADDR_CTRL;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Codes 69 and 79; connection outranks every other cause
    a_conn_trip: assert property (!board_seated && !trip_active |=>
        trip_active && trip_code == ($past(option_port_second) ? 8'h4F
                                                               : 8'h45))
        else $error("connection trip wrong");
    a_port_tens: assert property ($rose(trip_active) |->
        (trip_code >= 8'h46) == $past(option_port_second))
        else $error("trip code tens wrong");
    a_code_set: assert property (trip_active |-> trip_code inside
        {8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h45,
         8'h46, 8'h47, 8'h48, 8'h49, 8'h4F})
        else $error("trip code outside set");
    a_off_trip: assert property (trip_active |-> drive_off)
        else $error("output on while tripped");
    a_idle_code: assert property (!trip_active |-> trip_code == 8'h00)
        else $error("code while idle");
    // A CTRL write may carry the clear pulse, acting one edge later
    a_code_hold: assert property (trip_active && !trip_reset_req
        && !ctrl_wr && !$past(ctrl_wr) |=> trip_active && $stable(trip_code))
        else $error("trip not held");
    a_reset_clr: assert property (trip_active && trip_reset_req
        |=> !trip_active)
        else $error("trip not cleared");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
endmodule

bind eofm_top eofm_monitor eofm_monitor_i (.mclk, .sys_rst, .paddr, .psel,
    .penable, .pwrite, .pready, .board_seated, .option_port_second,
    .trip_reset_req, .drive_off, .trip_active, .trip_code);

`default_nettype wire

/* File: bench/eofm_enc_model.sv */
// Incremental encoder with line-driver pairs, one edge per step.
// Assumes step and dir driven synchronously to mclk.
`default_nettype none

module eofm_enc_model (
    // Clock
    input  wire logic mclk,
    // Commands
    input  wire logic step,
    input  wire logic dir,
    input  wire logic broken,
    // Line-driver pairs
    output logic      enc_a,
    output logic      enc_a_n,
    output logic      enc_b,
    output logic      enc_b_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Gray sequence, one phase changes per step
    logic [1:0] ph = 2'b00;
    always @(posedge mclk) begin
        if (step) begin
            ph <= dir ? {ph[0], ~ph[1]} : {~ph[0], ph[1]};
        end
    end
    assign enc_a = ph[1];
    assign enc_b = ph[0];
    // A cut return line floats to the level of its partner
    assign enc_a_n = broken ? ph[1] : ~ph[1];
    assign enc_b_n = ~ph[0];
endmodule

`default_nettype wire

/* File: bench/eofm_top_bench.sv */
// Self-checking bench of eofm_top with encoder model and APB master.
// Assumes the eofm_pkg package and the checker are compiled first.
`default_nettype none

`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
    mismatches++; $display("mismatch %s exp %h got %h", nm, ex, got); end end

module eofm_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import eofm_pkg::*;
    // ==========================================================
    // Signals
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, v, p;
    logic        pready, pslverr, last_err;
    logic        enc_a, enc_a_n, enc_b, enc_b_n;
    logic        board_seated = 1'b1;
    logic        option_port_second = 1'b0;
    logic        trip_reset_req = 1'b0;
    logic        drive_off, trip_active, irq;
    logic [7:0]  trip_code;
    logic        step = 1'b0;
    logic        dir = 1'b0;
    logic        broken = 1'b0;
    int          mismatches = 0;
    int          total_checks = 0;

    always #4 mclk = ~mclk;

    eofm_top #(.SPEED_WIN(64)) eofm_top_i (.mclk, .sys_rst, .paddr, .psel,
        .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .enc_a,
        .enc_a_n, .enc_b, .enc_b_n, .board_seated, .option_port_second,
        .trip_reset_req, .drive_off, .trip_active, .trip_code, .irq);
    eofm_enc_model eofm_enc_model_i (.mclk, .step, .dir, .broken, .enc_a,
        .enc_a_n, .enc_b, .enc_b_n);

    // ==========================================================
    // Bus and timing helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Answer taken at the edge that samples ready; watchdog ends a hang
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic wait_trip(input int lim);
        for (int n = 0; n < lim && trip_active !== 1'b1; n++) begin
            @(negedge mclk);
        end
    endtask
    task automatic clear_trip;
        @(posedge mclk);
        trip_reset_req <= 1'b1;
        @(posedge mclk);
        trip_reset_req <= 1'b0;
        @(negedge mclk);
        `CHK("trip_active", 1'b0, trip_active)
        `CHK("trip_code", 8'h00, trip_code)
    endtask
    task automatic spin(input int per, input logic d, input int len);
        for (int i = 0; i < len; i++) begin
            @(posedge mclk);
            step <= (i % per == 0);
            dir <= d;
        end
        @(posedge mclk);
        step <= 1'b0;
        @(negedge mclk);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs;
        apb(1'b0, ADDR_MAXFREQ, 32'h0, v);
        `CHK("maxfreq", 32'h0000FFFF, v)
        apb(1'b0, ADDR_OSLEVEL, 32'h0, v);
        `CHK("oslevel", 32'h0000006E, v)
        apb(1'b0, 8'h40, 32'h0, v);
        `CHK("unmapped err", 1'b1, last_err)
        `CHK("unmapped data", 32'h0, v)
    endtask
    // Port pin flips during the trip and must not move the code
    task automatic t_conn;
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_IRQ_EN, 32'h10);
            @(posedge mclk);
            option_port_second <= k[0];
            board_seated <= 1'b0;
            @(posedge mclk);
            board_seated <= 1'b1;
            option_port_second <= ~k[0];
            cyc(4);
            @(negedge mclk);
            `CHK("drive_off", 1'b1, drive_off)
            `CHK("code", k[0] ? 8'h4F : 8'h45, trip_code)
            `CHK("irq", 1'b1, irq)
            @(posedge mclk);
            option_port_second <= 1'b0;
            clear_trip;
            wr(ADDR_IRQ_CLR, 32'h10);
            cyc(2);
            @(negedge mclk);
            `CHK("irq clear", 1'b0, irq)
        end
    endtask
    task automatic t_loss;
        @(posedge mclk);
        broken <= 1'b1;
        cyc(1000);
        @(negedge mclk);
        `CHK("loss early", 1'b0, trip_active)
        wait_trip(400);
        `CHK("loss code", 8'h3C, trip_code)
        `CHK("loss off", 1'b1, drive_off)
        @(posedge mclk);
        broken <= 1'b0;
        clear_trip;
    endtask
    // 16 edges per 64-cycle window is exactly the limit
    task automatic t_ovspd;
        wr(ADDR_MAXFREQ, 32'h10);
        wr(ADDR_OSLEVEL, 32'h64);
        spin(4, 1'b1, 400);
        `CHK("speed at limit", 1'b0, trip_active)
        spin(2, 1'b0, 200);
        `CHK("overspeed", 8'h3D, trip_code)
        wr(ADDR_MAXFREQ, 32'h0000FFFF);
        clear_trip;
    endtask
    task automatic t_poserr;
        apb(1'b0, ADDR_POSITION, 32'h0, p);
        wr(ADDR_POSREF, p - 32'h000F4240);
        wr(ADDR_CTRL, 32'h1);
        cyc(4);
        @(negedge mclk);
        `CHK("dev at limit", 1'b0, trip_active)
        wr(ADDR_POSREF, p - 32'h000F4241);
        wait_trip(8);
        `CHK("dev code", 8'h3E, trip_code)
        wr(ADDR_CTRL, 32'h4);
        cyc(2);
        @(negedge mclk);
        `CHK("ctrl clear", 1'b0, trip_active)
    endtask
    task automatic t_range(input logic [7:0] a, input logic [31:0] ok,
                           input logic [31:0] bad, input logic [31:0] rst);
        wr(a, ok);
        wr(ADDR_CTRL, 32'h2);
        cyc(4);
        @(negedge mclk);
        `CHK("at limit", 1'b0, trip_active)
        wr(a, bad);
        wait_trip(8);
        `CHK("range code", 8'h3F, trip_code)
        wr(a, rst);
        wr(ADDR_CTRL, 32'h4);
    endtask

    // ==========================================================
    // Sequence and verdict
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #240000;
        mismatches++;
        end_sim;
    end
    initial begin
        cyc(5);
        sys_rst <= 1'b0;
        t_regs;
        t_conn;
        t_loss;
        t_ovspd;
        t_poserr;
        apb(1'b0, ADDR_POSITION, 32'h0, p);
        t_range(ADDR_FWDLIM, p, p - 32'h1, 32'h7FFFFFFF);
        t_range(ADDR_REVLIM, p, p + 32'h1, 32'h80000000);
        end_sim;
    end
endmodule

`default_nettype wire
